// File: rtl/tpo_ctrl.sv
// timer-triggered pattern output controller with APB register slave
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////

module tpo_ctrl
	import tpo_pkg::*;
(
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 soft_reset,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic  [11:0]         paddr,
	input  wire logic  [31:0]         pwdata,
	output logic       [31:0]         prdata,
	output logic                      pready,
	output logic                      pslverr,
	// timer events
	input  wire logic                 timer_low_half_event,
	input  wire logic                 timer_high_half_event,
	// outputs
	output logic       [NUM_PINS-1:0] event_driven_outputs,
	output logic                      missed_update_irq,
	output logic                      dma_sync_event
);

	typedef struct packed {
		logic                enable;
		logic [3:0]          event_source_select;
		logic [1:0]          edge_detect_select;
		logic                pin_update_style;
		logic [NUM_PINS-1:0] next_pin_pattern;
		logic [NUM_PINS-1:0] pin_change_mask;
		logic                missed_update_flag;
		logic                event_invert;
		logic                pattern_fresh;
		logic [NUM_PINS-1:0] pins;
		logic                irq_pulse;
		logic [31:0]         rdata;
	} tpo_state_t;

	tpo_state_t          s_q;
	tpo_state_t          s_d;
	logic                event_hit;
	logic [NUM_PINS-1:0] pins_next;
	logic                wr_en;
	logic                rd_en;

	// register decode for the pslverr response; the read and write paths compare paddr themselves
	function automatic logic is_mapped(input logic [11:0] a);
		return (a == ADDR_REVISION) || (a == ADDR_CTRL_STATUS);
	endfunction

	function automatic logic [31:0] ctrl_word(input tpo_state_t s);
		logic [31:0] w;
		w = '0;
		w[CTL_ENABLE]               = s.enable;
		w[CTL_SEL_HI:CTL_SEL_LO]    = s.event_source_select;
		w[CTL_EDGE_HI:CTL_EDGE_LO]  = s.edge_detect_select;
		w[CTL_STYLE]                = s.pin_update_style;
		w[CTL_PAT_HI:CTL_PAT_LO]    = s.next_pin_pattern;
		w[CTL_MASK_HI:CTL_MASK_LO]  = s.pin_change_mask;
		w[CTL_MISSED]               = s.missed_update_flag;
		w[CTL_INVERT]               = s.event_invert;
		w[CTL_STATE_HI:CTL_STATE_LO] = s.pins;
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	tpo_edge_detect u_edge (
		.pclk                  (pclk),
		.presetn               (presetn),
		.timer_low_half_event  (timer_low_half_event),
		.timer_high_half_event (timer_high_half_event),
		.use_high_half         (s_q.event_source_select != SEL_LOW_HALF),
		.event_invert          (s_q.event_invert),
		.edge_detect_select    (s_q.edge_detect_select),
		.event_hit             (event_hit)
	);

	tpo_pin_update u_pins (
		.pins_now         (s_q.pins),
		.next_pin_pattern (s_q.next_pin_pattern),
		.pin_change_mask  (s_q.pin_change_mask),
		.pin_update_style (s_q.pin_update_style),
		.pins_next        (pins_next)
	);

	////////////////////////////////////////////////////////////////////////////////

	// any bus master, processor or dma, reaches the same slave
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	always_comb begin
		s_d = s_q;
		s_d.irq_pulse = 1'b0;

		if (rd_en) begin
			if (paddr == ADDR_REVISION) begin
				s_d.rdata = REVISION_VALUE;
			end else if (paddr == ADDR_CTRL_STATUS) begin
				s_d.rdata = ctrl_word(s_q);
			end else begin
				s_d.rdata = '0;
			end
		end

		if (wr_en && paddr == ADDR_CTRL_STATUS) begin
			s_d.enable              = pwdata[CTL_ENABLE];
			s_d.event_source_select = pwdata[CTL_SEL_HI:CTL_SEL_LO];
			s_d.edge_detect_select  = pwdata[CTL_EDGE_HI:CTL_EDGE_LO];
			s_d.pin_update_style    = pwdata[CTL_STYLE];
			s_d.next_pin_pattern    = pwdata[CTL_PAT_HI:CTL_PAT_LO];
			s_d.pin_change_mask     = pwdata[CTL_MASK_HI:CTL_MASK_LO];
			s_d.event_invert        = pwdata[CTL_INVERT];
			s_d.pattern_fresh       = 1'b1;
			if (!pwdata[CTL_MISSED]) begin
				s_d.missed_update_flag = 1'b0;
			end
		end

		// event handling after the register write, so a set wins over a same-cycle clear
		if (s_q.enable && event_hit) begin
			s_d.pins = pins_next;
			if (!s_q.pattern_fresh) begin
				s_d.missed_update_flag = 1'b1;
				s_d.irq_pulse          = 1'b1;
			end
			s_d.pattern_fresh = wr_en && paddr == ADDR_CTRL_STATUS;
		end

		// synchronous software reset back to defaults
		if (soft_reset) begin
			s_d = '0;
		end
	end

	// free-running on the one clock, no halt input exists
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign pready               = 1'b1;
	assign pslverr              = psel & penable & ~is_mapped(paddr);
	assign prdata               = s_q.rdata;
	assign event_driven_outputs = s_q.pins;
	assign missed_update_irq    = s_q.irq_pulse;
	assign dma_sync_event       = s_q.irq_pulse;

endmodule // tpo_ctrl

// File: rtl/tpo_pkg.sv
// package with register map, field layout and encodings of the pattern output controller
package tpo_pkg;

	localparam logic [11:0] ADDR_REVISION    = 12'h000;
	localparam logic [11:0] ADDR_CTRL_STATUS = 12'h004;

	// revision word fields, values arbitrary
	localparam logic [31:0] REVISION_VALUE   = 32'h4000_0000;

	localparam int CTL_ENABLE     = 0;
	localparam int CTL_SEL_LO     = 1;
	localparam int CTL_SEL_HI     = 4;
	localparam int CTL_EDGE_LO    = 5;
	localparam int CTL_EDGE_HI    = 6;
	localparam int CTL_STYLE      = 7;
	localparam int CTL_PAT_LO     = 8;
	localparam int CTL_PAT_HI     = 11;
	localparam int CTL_MASK_LO    = 12;
	localparam int CTL_MASK_HI    = 15;
	localparam int CTL_MISSED     = 16;
	localparam int CTL_INVERT     = 17;
	localparam int CTL_STATE_LO   = 18;
	localparam int CTL_STATE_HI   = 21;

	localparam int NUM_PINS       = 4;

	typedef enum logic [1:0] {
		EDGE_NONE    = 2'b00,
		EDGE_RISING  = 2'b01,
		EDGE_FALLING = 2'b10,
		EDGE_BOTH    = 2'b11
	} tpo_edge_t;

	localparam logic       STYLE_DIRECT = 1'b0;
	localparam logic       STYLE_TOGGLE = 1'b1;
	localparam logic [3:0] SEL_LOW_HALF = 4'h0;

	localparam logic [3:0] PINS_RESET   = 4'h0;

endpackage : tpo_pkg

// File: rtl/tpo_edge_detect.sv
// edge detector for the selected, optionally inverted timer event
`timescale 1ns/10ps
module tpo_edge_detect
	import tpo_pkg::*;
(
	// clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// event and configuration
	input  wire logic  timer_low_half_event,
	input  wire logic  timer_high_half_event,
	input  wire logic  use_high_half,
	input  wire logic  event_invert,
	input  wire logic  [1:0] edge_detect_select,
	// result
	output logic       event_hit
);

	typedef struct packed {
		logic prev;
		logic primed;
	} tpo_edge_state_t;

	tpo_edge_state_t s_q;
	tpo_edge_state_t s_d;
	logic            level;

	always_comb begin
		level = (use_high_half ? timer_high_half_event : timer_low_half_event) ^ event_invert;
		s_d = s_q;
		s_d.prev = level;
		s_d.primed = 1'b1;
		event_hit = 1'b0;
		if (s_q.primed) begin
			case (tpo_edge_t'(edge_detect_select))
				EDGE_NONE:    event_hit = 1'b0;
				EDGE_RISING:  event_hit = level & ~s_q.prev;
				EDGE_FALLING: event_hit = ~level & s_q.prev;
				EDGE_BOTH:    event_hit = level ^ s_q.prev;
				default:      event_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule // tpo_edge_detect

// File: rtl/tpo_pin_update.sv
// next-level calculation of the four output pins
`timescale 1ns/10ps
module tpo_pin_update
	import tpo_pkg::*;
(
	// current state and configuration
	input  wire logic  [NUM_PINS-1:0] pins_now,
	input  wire logic  [NUM_PINS-1:0] next_pin_pattern,
	input  wire logic  [NUM_PINS-1:0] pin_change_mask,
	input  wire logic                 pin_update_style,
	// result
	output logic       [NUM_PINS-1:0] pins_next
);

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (!pin_change_mask[i]) begin
				pins_next[i] = pins_now[i];
			end else if (pin_update_style == STYLE_TOGGLE) begin
				pins_next[i] = pins_now[i] ^ next_pin_pattern[i];
			end else begin
				pins_next[i] = next_pin_pattern[i];
			end
		end
	end

endmodule // tpo_pin_update

// File: bench/tpo_ctrl_asserts.sv
// port assertions of the pattern output controller
`timescale 1ns/10ps
module tpo_ctrl_asserts
	import tpo_pkg::*;
(
	// clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        soft_reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// events and outputs
	input wire logic        timer_low_half_event,
	input wire logic        timer_high_half_event,
	input wire logic [3:0]  event_driven_outputs,
	input wire logic        missed_update_irq,
	input wire logic        dma_sync_event
);
	logic       lo_q, hi_q;
	logic [2:0] hist_q;
	// remembers input changes of the last three edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{lo_q, hi_q, hist_q} <= '0;
		end else begin
			lo_q   <= timer_low_half_event;
			hi_q   <= timer_high_half_event;
			hist_q <= {hist_q[1:0], (timer_low_half_event != lo_q) || (timer_high_half_event != hi_q)};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_dma_same: assert property (dma_sync_event == missed_update_irq)
		else $error("dma event differs from irq");
	chk_pins_cause: assert property (!$stable(event_driven_outputs) |-> hist_q[0] || $past(soft_reset))
		else $error("pins moved without event");
	chk_irq_cause: assert property (missed_update_irq |-> |hist_q)
		else $error("irq without event");
	chk_soft_clear: assert property (soft_reset |=> event_driven_outputs == 4'h0)
		else $error("pins kept after soft reset");
	chk_rev_read: assert property (psel && penable && !pwrite && paddr == ADDR_REVISION |-> prdata == REVISION_VALUE)
		else $error("revision word wrong");
	chk_bad_addr: assert property (psel && penable && paddr != ADDR_REVISION && paddr != ADDR_CTRL_STATUS
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_good_addr: assert property (psel && penable && (paddr == ADDR_REVISION || paddr == ADDR_CTRL_STATUS)
		|-> !pslverr)
		else $error("mapped access refused");
	chk_ready_now: assert property (psel && penable |-> pready)
		else $error("access not completed");
endmodule // tpo_ctrl_asserts
bind tpo_ctrl tpo_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timer_low_half_event(timer_low_half_event), .timer_high_half_event(timer_high_half_event),
	.event_driven_outputs(event_driven_outputs), .missed_update_irq(missed_update_irq),
	.dma_sync_event(dma_sync_event));

// File: bench/tpo_actuator.sv
// actuator model counting level changes on the output pins
`timescale 1ns/10ps
module tpo_actuator
	import tpo_pkg::*;
(
	// clock and pins from the controller
	input wire logic                pclk,
	input wire logic [NUM_PINS-1:0] pins,
	// observation
	output int                      n_moves
);
	logic [NUM_PINS-1:0] last_q = '0;
	initial n_moves = 0;
	always @(posedge pclk) begin
		if (pins !== last_q) n_moves++;
		last_q <= pins;
	end
endmodule // tpo_actuator

// File: bench/tpo_ctrl_tb_top.sv
// self-checking bench of the pattern output controller
`timescale 1ns/10ps
module tpo_ctrl_tb_top;
	import tpo_pkg::*;
	logic pclk = 0, presetn = 0, soft_reset = 0, psel = 0, penable = 0, pwrite = 0, lo = 0, hi = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, irq, dma;
	logic [3:0] edo;
	int failures = 0, n_checks = 0, seed = 2, n_irq = 0, n_dma = 0, n_moves, m_moves = 0;
	int pins = 0, old, flag = 0, fresh = 0, prev = 0, exp_irq = 0, cfg, en, s, hit;
	always #25 pclk = ~pclk;
	tpo_ctrl uut (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_low_half_event(lo), .timer_high_half_event(hi), .event_driven_outputs(edo),
		.missed_update_irq(irq), .dma_sync_event(dma));
	tpo_actuator act (.pclk(pclk), .pins(edo), .n_moves(n_moves));
	always @(posedge pclk) if (irq === 1'b1) n_irq++;
	always @(posedge pclk) if (dma === 1'b1) n_dma++;
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#1000000;
		failures++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(1, ADDR_REVISION, '1);
		chk("rwerr", err, 0);
		apb(0, ADDR_REVISION, 0);
		chk("rev", rd, REVISION_VALUE);
		apb(0, ADDR_CTRL_STATUS, 0);
		chk("ctl", rd, 0);
		apb(1, 12'h008, '1);
		chk("bwerr", err, 1);
		apb(0, 12'h008, 0);
		chk("bad", {rd[30:0], err}, 1);
		for (int i = 0; i < 40; i++) begin
			// fields set before enable, edge/style/polarity swept
			cfg = ($random(seed) & 32'h1ff1e) | (i[1:0] << 5) | (i[2] << 7) | (i[3] << 17);
			en = (i % 5 != 4);
			apb(1, ADDR_CTRL_STATUS, cfg);
			apb(1, ADDR_CTRL_STATUS, cfg | en);
			flag &= cfg[16];
			fresh = 1;
			prev = (cfg[4:1] != 0 ? hi : lo) ^ cfg[17];
			for (int j = 0; j < 3; j++) begin
				@(posedge pclk);
				{lo, hi} <= 2'($random(seed));
				repeat (4) @(posedge pclk);
				s = (cfg[4:1] != 0 ? hi : lo) ^ cfg[17];
				hit = en && s != prev && cfg[6 - s];
				prev = s;
				if (hit) begin
					if (!fresh) begin
						flag = 1;
						exp_irq++;
					end
					fresh = 0;
					old = pins;
					pins = pins & ~cfg[15:12] | cfg[15:12] & (cfg[7] ? pins ^ cfg[11:8] : cfg[11:8]);
					if (pins != old) m_moves++;
				end
				apb(0, ADDR_CTRL_STATUS, 0);
				chk("ctl", rd, {10'h0, pins[3:0], cfg[17], flag[0], cfg[15:1], en[0]});
				chk("irq", n_irq, exp_irq);
				chk("dma", n_dma, exp_irq);
				chk("pins", edo, pins);
			end
		end
		@(posedge pclk);
		soft_reset <= 1;
		@(posedge pclk);
		soft_reset <= 0;
		if (pins != 0) m_moves++;
		apb(0, ADDR_CTRL_STATUS, 0);
		chk("soft", rd, 0);
		chk("moves", n_moves, m_moves);
		// fields loaded, then a mid-run hardware reset must clear them
		apb(1, ADDR_CTRL_STATUS, 32'h0002fffe);
		apb(0, ADDR_CTRL_STATUS, 0);
		chk("cfg", rd, 32'h0002fffe);
		@(posedge pclk);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		apb(0, ADDR_CTRL_STATUS, 0);
		chk("hard", rd, 0);
		finish_test;
	end
endmodule // tpo_ctrl_tb_top
